// >>> hw/host_port_pkg.sv
package host_port_pkg;

	// Interface mode codes carried on the three strap pins
	typedef enum logic [2:0] {
		MODE_I2C = 3'h0,
		MODE_SPI3 = 3'h1,
		MODE_SPI4 = 3'h2,
		MODE_P8_6800 = 3'h4,
		MODE_P8_8080 = 3'h5,
		MODE_P16_6800 = 3'h6,
		MODE_P16_8080 = 3'h7
	} host_mode_type;

	typedef enum logic [2:0] {
		I2C_IDLE = 3'h0,
		I2C_ADDR = 3'h1,
		I2C_CTRL = 3'h2,
		I2C_DATA = 3'h3,
		I2C_SKIP = 3'h4
	} i2c_state_type;

	localparam int DATA_PINS = 16;
	localparam int CTRL_PINS = 5;
	localparam logic [3:0] SPI4_LAST_BIT = 4'h7;
	localparam logic [3:0] SPI3_LAST_BIT = 4'h8;
	localparam logic [2:0] I2C_LAST_BIT = 3'h7;
	localparam logic [5:0] I2C_ADDR_BASE = 6'h1E;
	localparam int CTRL_CONT_BIT = 7;
	localparam int CTRL_DC_BIT = 6;
	localparam int PIN_SCLK = 0;
	localparam int PIN_SERIAL_INPUT_LINE = 1;
	localparam int PIN_SDA_OUT = 2;
	localparam logic [6:0] COLUMN_RESET = 7'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	// All host pins, sampled as one group
	typedef struct packed {
		logic [DATA_PINS-1:0] data;
		logic strobe_e;
		logic rw_wr;
		logic cs_n;
		logic dc;
		logic hw_rst_n;
	} pin_bundle_type;

	typedef struct packed {
		logic is_data;
		logic [15:0] value;
	} host_write_type;

endpackage : host_port_pkg

// >>> hw/host_port.sv
`timescale 1ns/1ps

module host_port
	import host_port_pkg::*;
(
	// Core clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Serial clock, data pin 0 in the SPI modes; the I2C side samples pin 0 from pins_in
	input wire logic serial_clk,
	// Host pins
	input wire pin_bundle_type pins_in,
	input wire logic [2:0] interface_mode_strap,
	output logic [DATA_PINS-1:0] data_out_q,
	output logic [DATA_PINS-1:0] data_oe_q,
	// Write stream to the command decoder
	output logic wr_valid_q,
	output host_write_type wr_word_q,
	// Read-back from core
	input wire logic [15:0] status_in,
	input wire logic [15:0] pixel_in,
	output logic rd_req_q,
	// State
	output host_mode_type mode_q,
	output logic [6:0] column_q
);

	pin_bundle_type sync1_q;
	pin_bundle_type sync2_q;
	pin_bundle_type prev_q;
	logic [2:0] strap1_q;
	logic [2:0] strap2_q;
	logic hw_rst;
	logic parallel;
	logic wide;
	logic is_6800;
	logic [15:0] bus_val;
	logic wr_edge;
	logic rd_done;
	logic rd_phase;
	logic [15:0] read_buf_q;

	// Serial link side
	logic link_clr;
	logic spi3_l1_q;
	logic spi3_l2_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic dc_bit_q;
	logic [8:0] link_word_q;
	logic link_tog_q;
	logic tog1_q;
	logic tog2_q;
	logic tog3_q;
	logic spi_evt;

	// I2C
	i2c_state_type i2c_q;
	logic [2:0] i2c_cnt_q;
	logic [6:0] i2c_sh_q;
	logic i2c_stream_q;
	logic i2c_dc_q;
	logic ack_pend_q;
	logic ack_drive_q;
	logic ack_clk_q;
	logic scl_rise;
	logic scl_fall;
	logic i2c_start;
	logic i2c_stop;
	logic [7:0] i2c_byte;
	logic i2c_wr;

	// Two-flop synchronisers for every pin
	always_ff @(posedge ref_clk) begin
		sync1_q <= pins_in;
		sync2_q <= sync1_q;
		prev_q <= sync2_q;
		strap1_q <= interface_mode_strap;
		strap2_q <= strap1_q;
	end

	assign hw_rst = rst | ~sync2_q.hw_rst_n;

	// Strap is caught while reset is held
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_q <= host_mode_type'(strap2_q);
		end
	end

	assign parallel = mode_q[2];
	assign wide = mode_q[1];
	assign is_6800 = ~mode_q[0];
	// Narrow modes take the low byte only
	assign bus_val = wide ? prev_q.data : {8'h00, prev_q.data[7:0]};

	always_comb begin
		wr_edge = 1'b0;
		rd_done = 1'b0;
		rd_phase = 1'b0;
		if (parallel && !prev_q.cs_n) begin
			if (is_6800) begin
				// Falling enable ends the cycle; the R/W pin decides direction
				if (prev_q.strobe_e && !sync2_q.strobe_e) begin
					wr_edge = !prev_q.rw_wr;
					rd_done = prev_q.rw_wr;
				end
				rd_phase = sync2_q.strobe_e && sync2_q.rw_wr;
			end else begin
				wr_edge = !prev_q.rw_wr && sync2_q.rw_wr;
				rd_done = !prev_q.strobe_e && sync2_q.strobe_e;
				rd_phase = !sync2_q.strobe_e;
			end
		end
	end

	// Link bit counter and shift register: cleared by deselect or by the hardware reset pin
	assign link_clr = pins_in.cs_n | ~pins_in.hw_rst_n;

	always_ff @(posedge serial_clk) begin
		spi3_l1_q <= (mode_q == MODE_SPI3);
		spi3_l2_q <= spi3_l1_q;
	end

	always_ff @(posedge serial_clk or posedge link_clr) begin
		if (link_clr) begin
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			dc_bit_q <= 1'b0;
		end else begin
			if (spi3_l2_q && bit_cnt_q == 4'h0) begin
				dc_bit_q <= pins_in.data[PIN_SERIAL_INPUT_LINE];
			end else begin
				shift_q <= {shift_q[6:0], pins_in.data[PIN_SERIAL_INPUT_LINE]};
			end
			if (bit_cnt_q == (spi3_l2_q ? SPI3_LAST_BIT : SPI4_LAST_BIT)) begin
				bit_cnt_q <= 4'h0;
			end else begin
				bit_cnt_q <= bit_cnt_q + 4'h1;
			end
		end
	end

	// Completed word and toggle; word held until the next frame ends
	always_ff @(posedge serial_clk or negedge pins_in.hw_rst_n) begin
		if (!pins_in.hw_rst_n) begin
			link_word_q <= 9'h000;
			link_tog_q <= 1'b0;
		end else if (!pins_in.cs_n) begin
			if (spi3_l2_q && bit_cnt_q == SPI3_LAST_BIT) begin
				link_word_q <= {dc_bit_q, shift_q[6:0],
					pins_in.data[PIN_SERIAL_INPUT_LINE]};
				link_tog_q <= ~link_tog_q;
			end else if (!spi3_l2_q && bit_cnt_q == SPI4_LAST_BIT) begin
				// Select pin sampled on the same clock as the last bit
				link_word_q <= {pins_in.dc, shift_q[6:0],
					pins_in.data[PIN_SERIAL_INPUT_LINE]};
				link_tog_q <= ~link_tog_q;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		tog1_q <= link_tog_q;
		tog2_q <= tog1_q;
		tog3_q <= tog2_q;
	end

	assign spi_evt = (tog2_q ^ tog3_q) &&
		(mode_q == MODE_SPI3 || mode_q == MODE_SPI4);

	// I2C bus events from the synchronised pins
	assign scl_rise = sync2_q.data[PIN_SCLK] && !prev_q.data[PIN_SCLK];
	assign scl_fall = !sync2_q.data[PIN_SCLK] && prev_q.data[PIN_SCLK];
	assign i2c_start = sync2_q.data[PIN_SCLK] && prev_q.data[PIN_SCLK] &&
		prev_q.data[PIN_SERIAL_INPUT_LINE] && !sync2_q.data[PIN_SERIAL_INPUT_LINE];
	assign i2c_stop = sync2_q.data[PIN_SCLK] && prev_q.data[PIN_SCLK] &&
		!prev_q.data[PIN_SERIAL_INPUT_LINE] && sync2_q.data[PIN_SERIAL_INPUT_LINE];
	assign i2c_byte = {i2c_sh_q, sync2_q.data[PIN_SERIAL_INPUT_LINE]};
	assign i2c_wr = (mode_q == MODE_I2C) && scl_rise && !ack_clk_q &&
		i2c_cnt_q == I2C_LAST_BIT && i2c_q == I2C_DATA;

	always_ff @(posedge ref_clk) begin
		if (hw_rst || mode_q != MODE_I2C || i2c_stop) begin
			i2c_q <= I2C_IDLE;
			i2c_cnt_q <= 3'h0;
			i2c_sh_q <= 7'h00;
			i2c_stream_q <= 1'b0;
			i2c_dc_q <= 1'b0;
			ack_pend_q <= 1'b0;
			ack_drive_q <= 1'b0;
			ack_clk_q <= 1'b0;
		end else if (i2c_start) begin
			i2c_q <= I2C_ADDR;
			i2c_cnt_q <= 3'h0;
			ack_pend_q <= 1'b0;
			ack_drive_q <= 1'b0;
			ack_clk_q <= 1'b0;
		end else if (scl_fall) begin
			if (ack_drive_q) begin
				ack_drive_q <= 1'b0;
			end else if (ack_pend_q) begin
				ack_drive_q <= 1'b1;
				ack_pend_q <= 1'b0;
			end
		end else if (scl_rise && ack_clk_q) begin
			ack_clk_q <= 1'b0;
		end else if (scl_rise && i2c_q != I2C_IDLE) begin
			// One bit per clock period
			i2c_sh_q <= i2c_byte[6:0];
			i2c_cnt_q <= i2c_cnt_q + 3'h1;
			if (i2c_cnt_q == I2C_LAST_BIT) begin
				ack_clk_q <= 1'b1;
				unique case (i2c_q)
					I2C_ADDR: begin
						if (i2c_byte[7:1] == {I2C_ADDR_BASE,
							sync2_q.dc}) begin
							ack_pend_q <= 1'b1;
							// Read direction has no data path
							i2c_q <= i2c_byte[0] ? I2C_SKIP
								: I2C_CTRL;
						end else begin
							i2c_q <= I2C_SKIP;
						end
					end
					I2C_CTRL: begin
						ack_pend_q <= 1'b1;
						i2c_stream_q <= !i2c_byte[CTRL_CONT_BIT];
						i2c_dc_q <= i2c_byte[CTRL_DC_BIT];
						i2c_q <= I2C_DATA;
					end
					I2C_DATA: begin
						ack_pend_q <= 1'b1;
						i2c_q <= i2c_stream_q ? I2C_DATA : I2C_CTRL;
					end
					I2C_SKIP: begin
						ack_clk_q <= 1'b1;
					end
					I2C_IDLE: begin
						ack_clk_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// Column pointer steps on each display byte over I2C
	always_ff @(posedge ref_clk) begin
		if (hw_rst) begin
			column_q <= COLUMN_RESET;
		end else if (i2c_wr && i2c_dc_q) begin
			column_q <= column_q + 7'h01;
		end
	end

	// Write stream to the decoder, one pulse per word
	always_ff @(posedge ref_clk) begin
		if (hw_rst) begin
			wr_valid_q <= 1'b0;
			wr_word_q <= '0;
		end else begin
			wr_valid_q <= wr_edge || spi_evt || i2c_wr;
			if (wr_edge) begin
				wr_word_q <= {prev_q.dc, bus_val};
			end else if (spi_evt) begin
				wr_word_q <= {link_word_q[8], 8'h00,
					link_word_q[7:0]};
			end else if (i2c_wr) begin
				wr_word_q <= {i2c_dc_q, 8'h00, i2c_byte};
			end
		end
	end

	// Display reads are pipelined: each read shows the prior fetch
	always_ff @(posedge ref_clk) begin
		if (hw_rst) begin
			rd_req_q <= 1'b0;
			read_buf_q <= WORD_RESET;
		end else begin
			rd_req_q <= rd_done && prev_q.dc;
			if (rd_req_q) begin
				read_buf_q <= pixel_in;
			end
		end
	end

	// Pin drivers; serial modes only ever drive the acknowledge pin
	always_ff @(posedge ref_clk) begin
		if (hw_rst) begin
			data_out_q <= WORD_RESET;
			data_oe_q <= WORD_RESET;
		end else if (parallel && rd_phase && !sync2_q.cs_n) begin
			data_out_q <= sync2_q.dc ? read_buf_q : status_in;
			data_oe_q <= wide ? 16'hFFFF : 16'h00FF;
		end else begin
			data_out_q <= WORD_RESET;
			data_oe_q <= WORD_RESET;
			data_oe_q[PIN_SDA_OUT] <= ack_drive_q;
		end
	end

endmodule : host_port

// >>> bench/host_port_props.sv
`timescale 1ns/1ps
module host_port_props
	import host_port_pkg::*;
(
	// Watched ports
	input wire logic ref_clk,
	input wire logic rst,
	input wire pin_bundle_type pins_in,
	input wire logic [15:0] data_out_q,
	input wire logic [15:0] data_oe_q,
	input wire logic wr_valid_q,
	input wire host_write_type wr_word_q,
	input wire logic rd_req_q,
	input wire host_mode_type mode_q,
	input wire logic [6:0] column_q
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	wire m80 = mode_q[2] & mode_q[0];
	wire m68 = mode_q[2] & ~mode_q[0];
	wire ser = mode_q == MODE_SPI3 || mode_q == MODE_SPI4;
	sequence wr80;
		m80 && !pins_in.cs_n && $rose(pins_in.rw_wr);
	endsequence
	sequence wr68;
		m68 && !pins_in.cs_n && !pins_in.rw_wr && $fell(pins_in.strobe_e);
	endsequence
	sequence rd80;
		m80 && !pins_in.cs_n && $fell(pins_in.strobe_e);
	endsequence
	a_write_8080: assert property (wr80 |-> ##[1:4] wr_valid_q)
		else $error("8080 write lost");
	a_write_6800: assert property (wr68 |-> ##[1:4] wr_valid_q)
		else $error("6800 write lost");
	a_read_drive: assert property (rd80 |-> ##[1:4] data_oe_q[0])
		else $error("read not driven");
	a_serial_quiet: assert property (ser |-> !data_oe_q && !rd_req_q)
		else $error("serial mode drove bus");
	a_valid_pulse: assert property (wr_valid_q |=> !wr_valid_q)
		else $error("write pulse too long");
	a_narrow_word: assert property (wr_valid_q && !(mode_q[2] && mode_q[1])
		|-> wr_word_q.value[15:8] == 8'h00)
		else $error("high byte set");
	a_ack_pin: assert property (mode_q == MODE_I2C |-> data_oe_q[15:3] == 13'h0
		&& data_oe_q[1:0] == 2'h0 && !(data_oe_q[2] && data_out_q[2]))
		else $error("bad acknowledge drive");
	a_column_step: assert property ($changed(column_q) && column_q != 7'h00
		|-> column_q == $past(column_q) + 7'h01 && wr_valid_q
		&& wr_word_q.is_data)
		else $error("column step wrong");
endmodule : host_port_props

bind host_port host_port_props u_host_port_props (
	.ref_clk(ref_clk), .rst(rst), .pins_in(pins_in),
	.data_out_q(data_out_q), .data_oe_q(data_oe_q), .wr_valid_q(wr_valid_q),
	.wr_word_q(wr_word_q), .rd_req_q(rd_req_q), .mode_q(mode_q),
	.column_q(column_q)
);

// >>> bench/mcu_host_model.sv
`timescale 1ns/1ps
module mcu_host_model
	import host_port_pkg::*;
(
	// Core clock and design drive
	input wire logic ref_clk,
	input wire logic [15:0] oe,
	input wire logic [15:0] dout,
	// Host pins
	output pin_bundle_type pins
);
	pin_bundle_type drv;
	// Acknowledge output pulls the shared data line low
	always_comb begin
		pins = drv;
		pins.data[1] = drv.data[1] & ~(oe[2] & ~dout[2]);
	end
	task automatic idle(input logic hi, input logic [1:0] lines);
		// One assignment so the bundle changes once per time step
		drv <= '{data: {14'h0000, lines}, strobe_e: hi, rw_wr: hi,
			cs_n: 1'b1, dc: 1'b0, hw_rst_n: 1'b1};
	endtask : idle
	task automatic par(input logic m68, rd, dc, input logic [15:0] d);
		@(posedge ref_clk);
		drv.cs_n <= 1'b0;
		drv.dc <= dc;
		drv.data <= rd ? ~drv.data : d;
		if (m68) begin
			drv.rw_wr <= rd;
			drv.strobe_e <= 1'b1;
		end else if (rd)
			drv.strobe_e <= 1'b0;
		else
			drv.rw_wr <= 1'b0;
		repeat (5) @(posedge ref_clk);
		drv.strobe_e <= ~m68;
		drv.rw_wr <= ~m68 | rd;
		repeat (5) @(posedge ref_clk);
		drv.cs_n <= 1'b1;
		drv.data <= 16'h0000;
	endtask : par
	task automatic spi(input logic three, dc, input logic [7:0] b);
		logic [8:0] w;
		w = {dc, b};
		#3;
		repeat (2) begin
			#24 drv.data[0] = 1'b1;
			#24 drv.data[0] = 1'b0;
		end
		drv.dc = dc & ~three;
		drv.cs_n = 1'b0;
		for (int i = three ? 8 : 7; i >= 0; i--) begin
			drv.data[1] = w[i];
			#24 drv.data[0] = 1'b1;
			#24 drv.data[0] = 1'b0;
		end
		#24 drv.cs_n = 1'b1;
		drv.data[1] = 1'b0;
	endtask : spi
	task automatic i2c_bit(input logic v, output logic got);
		drv.data[1] = v;
		#48 drv.data[0] = 1'b1;
		#48 got = pins.data[1];
		#48 drv.data[0] = 1'b0;
		#48;
	endtask : i2c_bit
	task automatic i2c_frame(input logic sa0, input logic [31:0] b,
		output logic [3:0] ack);
		logic x;
		drv.dc = sa0;
		#3 drv.data[1] = 1'b0;
		#48 drv.data[0] = 1'b0;
		for (int k = 3; k >= 0; k--) begin
			for (int i = 7; i >= 0; i--)
				i2c_bit(b[8*k+i], x);
			i2c_bit(1'b1, x);
			ack[k] = ~x;
		end
		drv.data[1] = 1'b0;
		#48 drv.data[0] = 1'b1;
		#48 drv.data[1] = 1'b1;
		#48;
	endtask : i2c_frame
endmodule : mcu_host_model

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import host_port_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] strap = 3'h0;
	logic [15:0] status_in = 16'h0000;
	logic [15:0] pixel_in = 16'h0000;
	pin_bundle_type pins;
	logic [15:0] data_out_q, data_oe_q, seen;
	logic wr_valid_q, rd_req_q;
	host_write_type wr_word_q, got;
	host_mode_type mode_q;
	logic [6:0] column_q;
	logic [3:0] acks;
	int n_got = 0, exp_n = 0, fail_count = 0, n_compared = 0, n_rd = 0;
	always #4 ref_clk = ~ref_clk;
	mcu_host_model u_mcu_host_model (.ref_clk(ref_clk), .oe(data_oe_q),
		.dout(data_out_q), .pins(pins));
	host_port u_host_port (.ref_clk(ref_clk), .rst(rst),
		.serial_clk(pins.data[0]), .pins_in(pins),
		.interface_mode_strap(strap), .data_out_q(data_out_q),
		.data_oe_q(data_oe_q), .wr_valid_q(wr_valid_q), .wr_word_q(wr_word_q),
		.status_in(status_in), .pixel_in(pixel_in), .rd_req_q(rd_req_q),
		.mode_q(mode_q), .column_q(column_q));
	always @(posedge ref_clk) begin
		if (wr_valid_q === 1'b1) begin
			got <= wr_word_q;
			n_got <= n_got + 1;
		end
		if (data_oe_q[0] === 1'b1)
			seen <= data_out_q;
		if (rd_req_q === 1'b1)
			n_rd <= n_rd + 1;
	end
	task automatic chk(input string what, input logic [16:0] e, a);
		n_compared++;
		if (a !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, e, a);
		end
	endtask : chk
	task automatic word(input logic dc, input logic [15:0] v);
		exp_n++;
		chk("word", {dc, v}, got);
		chk("count", 17'(exp_n), 17'(n_got));
	endtask : word
	task automatic restart(input logic [2:0] m);
		@(posedge ref_clk);
		rst <= 1'b1;
		strap <= m;
		u_mcu_host_model.idle(m[2] & m[0], m == 3'h0 ? 2'h3 : 2'h0);
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk("mode", {14'h0000, m}, {14'h0000, mode_q});
	endtask : restart
	task automatic spi_case(input logic three, dc, input logic [7:0] b);
		u_mcu_host_model.spi(three, dc, b);
		repeat (6) @(posedge ref_clk);
		word(dc, {8'h00, b});
	endtask : spi_case
	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	initial begin
		u_mcu_host_model.idle(1'b0, 2'h0);
		restart(MODE_P16_8080);
		u_mcu_host_model.par(1'b0, 1'b0, 1'b0, 16'hA51C);
		word(1'b0, 16'hA51C);
		u_mcu_host_model.par(1'b0, 1'b0, 1'b1, 16'h3CF0);
		word(1'b1, 16'h3CF0);
		status_in <= 16'h5AA5;
		pixel_in <= 16'hBE6F;
		u_mcu_host_model.par(1'b0, 1'b1, 1'b0, 16'h0000);
		chk("status", {1'b0, 16'h5AA5}, {1'b0, seen});
		u_mcu_host_model.par(1'b0, 1'b1, 1'b1, 16'h0000);
		chk("dummy", {1'b0, WORD_RESET}, {1'b0, seen});
		u_mcu_host_model.par(1'b0, 1'b1, 1'b1, 16'h0000);
		chk("pixel", {1'b0, 16'hBE6F}, {1'b0, seen});
		chk("reads", 17'h00002, 17'(n_rd));
		restart(MODE_P8_6800);
		u_mcu_host_model.par(1'b1, 1'b0, 1'b1, 16'h00C6);
		word(1'b1, 16'h00C6);
		u_mcu_host_model.par(1'b1, 1'b1, 1'b0, 16'h0000);
		chk("status", {9'h000, 8'hA5}, {9'h000, seen[7:0]});
		restart(MODE_SPI4);
		spi_case(1'b0, 1'b1, 8'hB4);
		restart(MODE_SPI3);
		spi_case(1'b1, 1'b1, 8'h96);
		spi_case(1'b1, 1'b0, 8'h69);
		restart(MODE_I2C);
		u_mcu_host_model.i2c_frame(1'b1, 32'h7A40_5AC3, acks);
		chk("acks", 17'h0F, {13'h0, acks});
		chk("column", 17'h02, {10'h0, column_q});
		exp_n++;
		word(1'b1, 16'h00C3);
		u_mcu_host_model.i2c_frame(1'b1, 32'h7840_1111, acks);
		chk("acks", 17'h00, {13'h0, acks});
		chk("count", 17'(exp_n), 17'(n_got));
		summarize();
	end
endmodule : tb_top
